/* File: hdl/arac_pkg.sv */
// Package for the primary result accumulator and comparator block.
// Assumes a 32-bit AHB-Lite bus and a 24-bit primary result path.
package arac_pkg;

  localparam logic [31:0] ARAC_MAG_LIMIT_ADDR = 32'hFFFF053C;
  localparam logic [31:0] ARAC_HIT_LIMIT_ADDR = 32'hFFFF0540;
  localparam logic [31:0] ARAC_HIT_COUNT_ADDR = 32'hFFFF0544;
  localparam logic [31:0] ARAC_SUM_ADDR = 32'hFFFF0548;
  localparam logic [31:0] ARAC_SUM_LIMIT_ADDR = 32'hFFFF054C;
  localparam logic [31:0] ARAC_SETUP_ADDR = 32'hFFFF0550;
  localparam logic [31:0] ARAC_STATE_ADDR = 32'hFFFF0554;
  localparam logic [31:0] ARAC_MASK_ADDR = 32'hFFFF0558;

  localparam logic [15:0] ARAC_MAG_LIMIT_RST = 16'h0000;
  localparam logic [7:0] ARAC_HIT_LIMIT_RST = 8'h01;
  localparam logic [31:0] ARAC_SUM_LIMIT_RST = 32'h00000000;
  localparam logic [2:0] ARAC_SETUP_RST = 3'h0;
  localparam logic [2:0] ARAC_STATE_RST = 3'h0;
  localparam logic [2:0] ARAC_MASK_RST = 3'h0;

  // Setup register fields
  localparam int ARAC_SETUP_SUM_EN = 0;
  localparam int ARAC_SETUP_CNT_EN = 1;
  localparam int ARAC_SETUP_CNT_DEC = 2;

  // Status and mask register fields
  localparam int ARAC_ST_READY = 0;
  localparam int ARAC_ST_HIT = 1;
  localparam int ARAC_ST_SUM_OVER = 2;

  localparam int ARAC_RESULT_W = 24;
  localparam int ARAC_MAG_W = 16;

endpackage

/* File: hdl/arac_magcmp.sv */
// Magnitude comparator for one primary result.
// Assumes result is two's complement when bipolar is high.
`timescale 1ns/1ps
module arac_magcmp
  import arac_pkg::*;
(
  input wire logic [ARAC_RESULT_W-1:0] result,
  input wire logic bipolar,
  input wire logic [ARAC_MAG_W-1:0] limit,
  output logic at_or_above
);

  logic [ARAC_RESULT_W-1:0] mag;

  always_comb begin
    if (bipolar && result[ARAC_RESULT_W-1]) begin
      mag = ARAC_RESULT_W'(~result + 1'b1);
    end else begin
      mag = result;
    end
    // Top bits of the magnitude against the limit
    at_or_above = (mag[ARAC_RESULT_W-1 -: ARAC_MAG_W] >= limit);
  end

endmodule

/* File: hdl/arac_top.sv */
// Primary result accumulator, accumulator comparator and hit counter.
// Assumes one AHB-Lite master and result strobes on sys_clk.
//
// How it works
// R1 - An 8-bit read-only hit counter sits in the low byte of its register.
// R2 - A 32-bit read-only accumulator of primary results is bus readable.
// R3 - The accumulator clears when its enable drops or on reconfiguration.
// R4 - Software checks the ready flag before reading the accumulator.
// R5 - A 32-bit limit is held and the over flag sets when the sum exceeds it.
// R6 - The over flag raises the interrupt only when its mask bit is set.
// R7 - Results at or above the limit count up, below count down or zero.
// R8 - The hit flag sets one cycle after the counter equals the count limit.
// R9 - While enabled each new result is added once in its valid cycle.
`timescale 1ns/1ps
module arac_top
  import arac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic result_valid,
  input wire logic [ARAC_RESULT_W-1:0] result_data,
  input wire logic result_bipolar,
  input wire logic chan_reconfig,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic wr_pend_reg, wr_pend_next;
  logic [31:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [15:0] magnitude_limit_reg, magnitude_limit_next;
  logic [7:0] hit_count_limit_reg, hit_count_limit_next;
  logic [7:0] magnitude_hit_count_reg, magnitude_hit_count_next;
  logic [31:0] result_sum_reg, result_sum_next;
  logic [31:0] sum_limit_reg, sum_limit_next;
  logic [2:0] converter_setup_reg, converter_setup_next;
  logic [2:0] converter_state_reg, converter_state_next;
  logic [2:0] converter_irq_mask_reg, converter_irq_mask_next;
  logic irq_reg, irq_next;

  logic at_or_above;
  logic addr_phase;
  logic [2:0] set_bits;
  logic [2:0] clr_bits;
  logic [31:0] sum_add;

  arac_magcmp u_magcmp (
    .result(result_data),
    .bipolar(result_bipolar),
    .limit(magnitude_limit_reg),
    .at_or_above(at_or_above)
  );

  assign addr_phase = hsel && htrans[1] && hready;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  function automatic logic [31:0] read_word(input logic [31:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    unique case (a)
      ARAC_MAG_LIMIT_ADDR: d = {16'h0000, magnitude_limit_reg};
      ARAC_HIT_LIMIT_ADDR: d = {24'h000000, hit_count_limit_reg};
      ARAC_HIT_COUNT_ADDR: d = {24'h000000, magnitude_hit_count_reg}; // R1
      ARAC_SUM_ADDR: d = result_sum_reg; // R2
      ARAC_SUM_LIMIT_ADDR: d = sum_limit_reg;
      ARAC_SETUP_ADDR: d = {29'h0000000, converter_setup_reg};
      ARAC_STATE_ADDR: d = {29'h0000000, converter_state_reg};
      ARAC_MASK_ADDR: d = {29'h0000000, converter_irq_mask_reg};
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus and configuration registers

  always_comb begin
    wr_pend_next = addr_phase && hwrite;
    wr_addr_next = addr_phase ? haddr : wr_addr_reg;
    hrdata_next = (addr_phase && !hwrite) ? read_word(haddr) : hrdata_reg;

    magnitude_limit_next = magnitude_limit_reg;
    hit_count_limit_next = hit_count_limit_reg;
    sum_limit_next = sum_limit_reg;
    converter_setup_next = converter_setup_reg;
    converter_irq_mask_next = converter_irq_mask_reg;
    clr_bits = 3'h0;

    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        ARAC_MAG_LIMIT_ADDR: magnitude_limit_next = hwdata[15:0];
        ARAC_HIT_LIMIT_ADDR: hit_count_limit_next = hwdata[7:0];
        ARAC_SUM_LIMIT_ADDR: sum_limit_next = hwdata; // R5
        ARAC_SETUP_ADDR: converter_setup_next = hwdata[2:0];
        ARAC_STATE_ADDR: clr_bits = hwdata[2:0];
        ARAC_MASK_ADDR: converter_irq_mask_next = hwdata[2:0];
        default: clr_bits = 3'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
      hrdata_reg <= 32'h00000000;
      magnitude_limit_reg <= ARAC_MAG_LIMIT_RST;
      hit_count_limit_reg <= ARAC_HIT_LIMIT_RST;
      sum_limit_reg <= ARAC_SUM_LIMIT_RST;
      converter_setup_reg <= ARAC_SETUP_RST;
      converter_irq_mask_reg <= ARAC_MASK_RST;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
      magnitude_limit_reg <= magnitude_limit_next;
      hit_count_limit_reg <= hit_count_limit_next;
      sum_limit_reg <= sum_limit_next;
      converter_setup_reg <= converter_setup_next;
      converter_irq_mask_reg <= converter_irq_mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator

  always_comb begin
    sum_add = {{(32-ARAC_RESULT_W){result_data[ARAC_RESULT_W-1]
      & result_bipolar}}, result_data};
    result_sum_next = result_sum_reg;
    if (!converter_setup_reg[ARAC_SETUP_SUM_EN] || chan_reconfig) begin
      result_sum_next = 32'h00000000; // R3
    end else if (result_valid) begin
      result_sum_next = result_sum_reg + sum_add; // R9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_sum_reg <= 32'h00000000;
    end else begin
      result_sum_reg <= result_sum_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hit counter

  always_comb begin
    magnitude_hit_count_next = magnitude_hit_count_reg;
    if (chan_reconfig || !converter_setup_reg[ARAC_SETUP_CNT_EN]) begin
      magnitude_hit_count_next = 8'h00;
    end else if (result_valid) begin
      if (at_or_above) begin
        if (magnitude_hit_count_reg != 8'hFF) begin
          magnitude_hit_count_next = magnitude_hit_count_reg + 8'h01; // R7
        end
      end else if (converter_setup_reg[ARAC_SETUP_CNT_DEC]) begin
        if (magnitude_hit_count_reg != 8'h00) begin
          magnitude_hit_count_next = magnitude_hit_count_reg - 8'h01; // R7
        end
      end else begin
        magnitude_hit_count_next = 8'h00; // R7
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      magnitude_hit_count_reg <= 8'h00;
    end else begin
      magnitude_hit_count_reg <= magnitude_hit_count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over clear

  always_comb begin
    set_bits = 3'h0;
    set_bits[ARAC_ST_READY] = result_valid;
    set_bits[ARAC_ST_HIT] = converter_setup_reg[ARAC_SETUP_CNT_EN]
      && (magnitude_hit_count_reg == hit_count_limit_reg); // R8
    set_bits[ARAC_ST_SUM_OVER] = converter_setup_reg[ARAC_SETUP_SUM_EN]
      && ($signed(result_sum_reg) > $signed(sum_limit_reg)); // R5
    converter_state_next = (converter_state_reg & ~clr_bits) | set_bits;

    irq_next = |(converter_state_next & converter_irq_mask_next); // R6
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      converter_state_reg <= ARAC_STATE_RST;
      irq_reg <= 1'b0;
    end else begin
      converter_state_reg <= converter_state_next;
      irq_reg <= irq_next;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
  end

  assign hrdata = hrdata_reg;
  assign irq = irq_reg;

endmodule

/* File: testbench/arac_top_chk.sv */
// Port checker for the accumulator and comparator block.
// Bound to arac_top from the bench top; sees its ports only.
`timescale 1ns/1ps
module arac_top_chk
  import arac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic result_valid,
  input wire logic chan_reconfig,
  input wire logic irq
);
  logic take;
  logic wr_reg;
  logic wr_next;
  logic [31:0] addr_reg;
  assign take = hsel && htrans[1] && hready;
  assign wr_next = !rst && take && hwrite;
  always_ff @(posedge sys_clk) begin
    wr_reg <= wr_next;
    addr_reg <= haddr;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  a_rdata_hold: assert property (
    !$past(take && !hwrite) |-> $stable(hrdata))
    else $error("hrdata changed without a read");
  a_unmapped_zero: assert property (
    take && !hwrite && haddr > ARAC_MASK_ADDR |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_mask_quiet: assert property (
    wr_reg && addr_reg == ARAC_MASK_ADDR && hwdata[2:0] == 3'h0 |=> !irq)
    else $error("irq high with mask clear");
  a_irq_cause: assert property ($changed(irq) |->
    $past(result_valid) || $past(result_valid, 2) || $past(wr_reg)
    || $past(wr_reg, 2)
    || $past(chan_reconfig))
    else $error("irq moved without cause");
  a_reset_irq: assert property (disable iff (1'b0) rst |=> !irq)
    else $error("irq high after reset");
  a_reset_rdata: assert property (
    disable iff (1'b0) rst |=> hrdata == 32'h0)
    else $error("hrdata not zero after reset");
  c_result: cover property (result_valid);
  c_irq: cover property ($rose(irq));
  c_reconf: cover property (chan_reconfig);
endmodule

/* File: testbench/arac_result_src.sv */
// Model of the primary result path feeding the block.
// Driven by bench task calls; changes outputs after rising edges.
`timescale 1ns/1ps
module arac_result_src
  import arac_pkg::*;
(
  input wire logic sys_clk,
  output logic result_valid,
  output logic [ARAC_RESULT_W-1:0] result_data,
  output logic result_bipolar,
  output logic chan_reconfig
);
  initial begin
    result_valid = 1'b0;
    result_data = '0;
    result_bipolar = 1'b0;
    chan_reconfig = 1'b0;
  end
  // Data is inverted once the strobe drops
  task send(input logic [ARAC_RESULT_W-1:0] d, input logic b);
    @(posedge sys_clk);
    result_valid <= 1'b1;
    result_data <= d;
    result_bipolar <= b;
    @(posedge sys_clk);
    result_valid <= 1'b0;
    result_data <= ~d;
  endtask
  task reconfig;
    @(posedge sys_clk);
    chan_reconfig <= 1'b1;
    @(posedge sys_clk);
    chan_reconfig <= 1'b0;
  endtask
endmodule

/* File: testbench/arac_top_test.sv */
// Bench top: AHB-Lite master tasks and register-level tests.
// Uses arac_result_src as result source; binds the checker.
`timescale 1ns/1ps
module arac_top_test
  import arac_pkg::*;
;
  logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, irq, rv, rb, rc;
  logic [ARAC_RESULT_W-1:0] rd_data;
  int miscompares = 0, check_count = 0;
  always #2 sys_clk = ~sys_clk;
  arac_top dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .result_valid(rv), .result_data(rd_data),
    .result_bipolar(rb), .chan_reconfig(rc), .irq(irq));
  arac_result_src src (.sys_clk(sys_clk), .result_valid(rv),
    .result_data(rd_data), .result_bipolar(rb), .chan_reconfig(rc));
  task complete_run;
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e, input string n);
    xfer(a, 1'b0, hwdata);
    chk(n, e, hrdata);
  endtask
  initial begin
    #20000;
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ARAC_SUM_ADDR, 32'h0, "sum");
    rd(ARAC_SUM_LIMIT_ADDR, 32'h0, "limit");
    rd(ARAC_HIT_COUNT_ADDR, 32'h0, "count");
    rd(ARAC_HIT_LIMIT_ADDR, {24'h000000, ARAC_HIT_LIMIT_RST}, "hlim");
    rd(32'hFFFF0560, 32'h0, "unmapped");
    wr(ARAC_SUM_LIMIT_ADDR, 32'h150);
    wr(ARAC_SUM_ADDR, 32'h1234);
    rd(ARAC_SUM_ADDR, 32'h0, "sum");
    rd(ARAC_SUM_LIMIT_ADDR, 32'h150, "limit");
    wr(ARAC_SETUP_ADDR, 32'h1);
    wr(ARAC_MASK_ADDR, 32'h4);
    src.send(24'h100, 1'b0);
    src.send(24'h100, 1'b0);
    rd(ARAC_STATE_ADDR, 32'h5, "state");
    rd(ARAC_SUM_ADDR, 32'h200, "sum");
    chk("irq", 32'h1, {31'h0, irq});
    wr(ARAC_MASK_ADDR, 32'h0);
    rd(ARAC_MASK_ADDR, 32'h0, "mask");
    chk("irq", 32'h0, {31'h0, irq});
    wr(ARAC_SETUP_ADDR, 32'h0);
    wr(ARAC_SETUP_ADDR, 32'h1);
    rd(ARAC_SUM_ADDR, 32'h0, "sum");
    src.send(24'h10, 1'b0);
    src.reconfig;
    rd(ARAC_SUM_ADDR, 32'h0, "sum");
    src.send(24'hFFFFFB, 1'b1);
    src.send(24'h3, 1'b1);
    rd(ARAC_SUM_ADDR, 32'hFFFFFFFE, "sum");
    wr(ARAC_STATE_ADDR, 32'h7);
    wr(ARAC_MAG_LIMIT_ADDR, 32'h10);
    wr(ARAC_HIT_LIMIT_ADDR, 32'h3);
    wr(ARAC_SETUP_ADDR, 32'h2);
    repeat (2) src.send(24'h1000, 1'b0);
    rd(ARAC_HIT_COUNT_ADDR, 32'h2, "count");
    src.send(24'hFFF, 1'b0);
    rd(ARAC_HIT_COUNT_ADDR, 32'h0, "count");
    wr(ARAC_SETUP_ADDR, 32'h6);
    repeat (3) src.send(24'h1000, 1'b0);
    rd(ARAC_STATE_ADDR, 32'h3, "state");
    wr(ARAC_MASK_ADDR, 32'h2);
    src.send(24'hFFF, 1'b0);
    rd(ARAC_HIT_COUNT_ADDR, 32'h2, "count");
    chk("irq", 32'h1, {31'h0, irq});
    src.send(24'hFFF000, 1'b1);
    rd(ARAC_HIT_COUNT_ADDR, 32'h3, "count");
    complete_run;
  end
endmodule
bind arac_top arac_top_chk chk (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .result_valid(result_valid), .chan_reconfig(chan_reconfig), .irq(irq));
